// ==== design/spibm_defines.svh ====
`ifndef SPIBM_DEFINES_SVH
`define SPIBM_DEFINES_SVH

// timing figures, in their own units
`define SPIBM_REF_CLK_HZ 20000000
`define SPIBM_SCLK_MAX_HZ 16000000
`define SPIBM_SCLK_MIN_HZ 125000

// half serial period in ref_clk cycles: least rounds up, longest rounds down, never below one
`define SPIBM_HALF_RAW_MIN ((`SPIBM_REF_CLK_HZ + 2 * `SPIBM_SCLK_MAX_HZ - 1) / (2 * `SPIBM_SCLK_MAX_HZ))
`define SPIBM_HALF_MIN ((`SPIBM_HALF_RAW_MIN < 1) ? 1 : `SPIBM_HALF_RAW_MIN)
`define SPIBM_HALF_MAX (`SPIBM_REF_CLK_HZ / (2 * `SPIBM_SCLK_MIN_HZ))

// transaction length limits in bits
`define SPIBM_LEN_MIN 6'h01
`define SPIBM_LEN_MAX 6'h20

// receive buffer depth
`define SPIBM_BUF_DEPTH 2'h2

// reset values
`define SPIBM_RST_WORD 32'h0000_0000
`define SPIBM_RST_SEL 3'h7

`endif

// ==== design/spibm_pkg.sv ====
package spibm_pkg;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL, ST_DONE} spibm_state_e;

    typedef logic [31:0] spibm_word_t;

endpackage

// ==== design/spibm_top.sv ====
// What this block does
// - shift out and in together, same bit count, received word readable afterwards
// - length 1 to 32 bits, runs to the end without software help
// - serial clock rate set by divider, between 125 kHz and the top rate
// - mode 0: idle low, first bit before first edge, change falling, sample rising
// - mode 1: idle low, drive on rising, sample on falling
// - mode 2: idle high, first bit before first edge, change rising, sample falling
// - mode 3: idle high, drive on falling, sample on rising
// - three select outputs, no more than two asserted at once
// - automatic select drops between transactions; manual holds across many
// - selects active low; manual mode driven by software around a transfer
// - in reset all bus pins are inputs with pull-up until enabled
// - maskable completion interrupt plus a pollable completion flag
// - wire bit order selectable, LSB first or MSB first
// - data taken and returned in little or big endian byte order
// - option to delay the receive sampling edge
// - configured and selected, load transmit word and shift it with clock edges
`include "spibm_defines.svh"

module spibm_top
    import spibm_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic enable, // block enable, hands the pins to the block
    input wire logic [1:0] spiMode, // {polarity, phase}
    input wire logic lsbFirst, // 1: least significant bit first
    input wire logic bigEndian, // 1: byte order reversed on the wire
    input wire logic sampleDelay, // 1: sample half a period late
    input wire logic [6:0] clkDiv, // half period in ref_clk cycles, minus one
    input wire logic [5:0] xferLen, // bits per transaction, 1..32
    input wire logic selAuto, // 1: automatic select mode
    input wire logic [2:0] selChoose, // selects driven in automatic mode
    input wire logic [2:0] selManual, // selects driven in manual mode, 1 = asserted
    input wire logic startReq, // start a transaction
    output logic startReady, // start is taken this cycle if requested
    input wire logic [31:0] txData, // transmit word
    output logic busy, // transaction under way
    output logic rxValid, // received word available
    input wire logic rxReady, // consumer takes the received word
    output logic [31:0] rxData, // received word
    output logic doneFlag, // sticky completion flag
    input wire logic doneClear, // clears the completion flag
    input wire logic irqEnable, // completion interrupt mask, 1 = pass
    output logic irqOut, // completion interrupt, active high
    output logic slave_select_0, // select 0 pin out, active low
    output logic slave_select_1, // select 1 pin out, active low
    output logic slave_select_2, // select 2 pin out, active low
    output logic [2:0] selOeN, // select pin output enables, low = drive
    output logic serial_clock_out, // serial clock pin out
    output logic clkOeN, // serial clock output enable, low = drive
    output logic serial_data_out, // serial data pin out
    output logic doutOeN, // serial data output enable, low = drive
    input wire logic serial_data_in, // serial data pin in
    output logic pullUpEn // pin pull-ups on
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // reverse the byte order of the bytes that a len-bit word occupies
    function automatic spibm_word_t byteSwap(input spibm_word_t d, input logic [5:0] len);
        spibm_word_t r;
        logic [2:0] nb;
        r = `SPIBM_RST_WORD;
        nb = 3'((len + 6'h07) >> 3);
        for (int i = 0; i < 4; i++)
        begin
            if (3'(i) < nb)
            begin
                r[8 * i +: 8] = d[8 * (32'(nb) - 1 - i) +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] bitPos(input logic [4:0] idx, input logic [5:0] len, input logic lsb);
        return lsb ? idx : 5'(len - 6'h01 - {1'b0, idx});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    spibm_state_e state_ff;
    logic [6:0] divCnt_ff;
    logic [6:0] half_ff;
    logic [5:0] edgeCnt_ff;
    logic [5:0] len_ff;
    spibm_word_t txWord_ff;
    spibm_word_t rxWord_ff;
    logic cpol_ff;
    logic cpha_ff;
    logic lsb_ff;
    logic big_ff;
    logic dly_ff;
    logic pend_ff;
    logic [4:0] pendIdx_ff;
    logic sclk_ff;
    logic mosi_ff;
    logic [2:0] sel_ff;
    logic drvEn_ff;
    logic done_ff;
    logic misoMeta_ff;
    logic misoSync_ff;
    spibm_word_t buf_ff [2];
    logic wrPtr_ff;
    logic rdPtr_ff;
    logic [1:0] count_ff;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire logic [5:0] lenClamp;
    wire logic [6:0] divClamp;
    wire logic tick;
    wire logic inShift;
    wire logic lastEdge;
    wire logic sampleEdge;
    wire logic startFire;
    wire logic pushRx;
    wire logic popRx;
    wire logic [4:0] edgeBit;
    wire logic [4:0] nextBit;
    wire logic changeNow;
    wire logic [2:0] selReq;
    wire logic [2:0] selLim;
    wire spibm_word_t txLoad;

    assign lenClamp = (xferLen < `SPIBM_LEN_MIN) ? `SPIBM_LEN_MIN :
                      (xferLen > `SPIBM_LEN_MAX) ? `SPIBM_LEN_MAX : xferLen;
    assign divClamp = ({1'b0, clkDiv} + 8'h01 < 8'(`SPIBM_HALF_MIN)) ? 7'(`SPIBM_HALF_MIN - 1) :
                      ({1'b0, clkDiv} + 8'h01 > 8'(`SPIBM_HALF_MAX)) ? 7'(`SPIBM_HALF_MAX - 1) : clkDiv;
    assign tick = (divCnt_ff == half_ff);
    assign inShift = (state_ff == ST_SHIFT);
    assign lastEdge = ({1'b0, edgeCnt_ff} == 7'({len_ff, 1'b0} - 7'h01));
    // sample on leading edge for phase 0, trailing for phase 1
    assign sampleEdge = (edgeCnt_ff[0] == cpha_ff);
    // phase 0 changes on trailing edges, phase 1 drives on leading edges
    assign changeNow = cpha_ff ? ~edgeCnt_ff[0] : (edgeCnt_ff[0] & ~lastEdge);
    assign edgeBit = edgeCnt_ff[5:1];
    assign nextBit = cpha_ff ? edgeBit : 5'(edgeBit + 5'h01);
    // no start while busy or while the buffer has no room
    assign startReady = enable & (state_ff == ST_IDLE) & (count_ff < `SPIBM_BUF_DEPTH);
    assign startFire = startReq & startReady;
    assign busy = (state_ff != ST_IDLE);
    // byte order on the way in
    assign txLoad = bigEndian ? byteSwap(txData, lenClamp) : txData;
    assign pushRx = (state_ff == ST_DONE);
    assign popRx = rxReady & rxValid;
    assign rxValid = (count_ff != 2'h0);
    assign rxData = buf_ff[rdPtr_ff];
    // auto mode asserts only while busy, manual follows software
    assign selReq = selAuto ? (busy ? selChoose : 3'h0) : selManual;
    // a third simultaneous select is dropped
    assign selLim = (&selReq) ? 3'h3 : selReq;
    assign irqOut = done_ff & irqEnable;
    assign doneFlag = done_ff;
    assign slave_select_0 = sel_ff[0];
    assign slave_select_1 = sel_ff[1];
    assign slave_select_2 = sel_ff[2];
    assign serial_clock_out = sclk_ff;
    assign serial_data_out = mosi_ff;
    assign selOeN = {3{~drvEn_ff}};
    assign clkOeN = ~drvEn_ff;
    assign doutOeN = ~drvEn_ff;
    assign pullUpEn = ~drvEn_ff;

    ////////////////////////////////////////////////////////////////////////
    // input synchroniser

    always_ff @(posedge ref_clk)
    begin
        misoMeta_ff <= serial_data_in;
        misoSync_ff <= misoMeta_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge ref_clk)
    begin
        if (rst || !enable)
        begin
            state_ff <= ST_IDLE;
            divCnt_ff <= 7'h00;
            edgeCnt_ff <= 6'h00;
            pend_ff <= 1'b0;
        end
        else
        begin
            divCnt_ff <= (state_ff == ST_IDLE || tick) ? 7'h00 : 7'(divCnt_ff + 7'h01);
            unique case (state_ff)
                ST_IDLE:
                begin
                    edgeCnt_ff <= 6'h00;
                    pend_ff <= 1'b0;
                    if (startFire)
                    begin
                        state_ff <= ST_LEAD;
                    end
                end
                ST_LEAD:
                begin
                    if (tick)
                    begin
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    if (tick)
                    begin
                        edgeCnt_ff <= 6'(edgeCnt_ff + 6'h01);
                        // late sample taken at the following edge
                        pend_ff <= dly_ff & sampleEdge;
                        if (lastEdge)
                        begin
                            state_ff <= ST_TAIL;
                        end
                    end
                end
                ST_TAIL:
                begin
                    if (tick)
                    begin
                        pend_ff <= 1'b0;
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift data and serial clock

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            half_ff <= 7'h00;
            len_ff <= `SPIBM_LEN_MIN;
            txWord_ff <= `SPIBM_RST_WORD;
            rxWord_ff <= `SPIBM_RST_WORD;
            {cpol_ff, cpha_ff, lsb_ff, big_ff, dly_ff} <= 5'h00;
            pendIdx_ff <= 5'h00;
            sclk_ff <= 1'b0;
            mosi_ff <= 1'b0;
        end
        else if (startFire)
        begin
            half_ff <= divClamp;
            len_ff <= lenClamp;
            txWord_ff <= txLoad;
            rxWord_ff <= `SPIBM_RST_WORD;
            {cpol_ff, cpha_ff} <= spiMode;
            lsb_ff <= lsbFirst;
            big_ff <= bigEndian;
            dly_ff <= sampleDelay;
            // first bit valid before the first edge
            mosi_ff <= txLoad[bitPos(5'h00, lenClamp, lsbFirst)];
            sclk_ff <= spiMode[1];
        end
        else if (state_ff == ST_IDLE)
        begin
            // idle level follows polarity so the slave sees it before select
            sclk_ff <= spiMode[1];
        end
        else if (tick && (inShift || state_ff == ST_TAIL))
        begin
            if (inShift)
            begin
                // one serial clock edge per half period
                sclk_ff <= ~sclk_ff;
                if (changeNow)
                begin
                    mosi_ff <= txWord_ff[bitPos(nextBit, len_ff, lsb_ff)];
                end
                // normal sampling at the sample edge
                if (sampleEdge && !dly_ff)
                begin
                    rxWord_ff[bitPos(edgeBit, len_ff, lsb_ff)] <= misoSync_ff;
                end
                pendIdx_ff <= edgeBit;
            end
            if (pend_ff)
            begin
                rxWord_ff[bitPos(pendIdx_ff, len_ff, lsb_ff)] <= misoSync_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selects, pin ownership, completion flag

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sel_ff <= `SPIBM_RST_SEL;
            drvEn_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            sel_ff <= enable ? ~selLim : `SPIBM_RST_SEL;
            drvEn_ff <= enable;
            // completion sets, and a set beats a clear in the same cycle
            done_ff <= (done_ff & ~doneClear) | pushRx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry receive buffer; start waits for room so no word is lost

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wrPtr_ff <= 1'b0;
            rdPtr_ff <= 1'b0;
            count_ff <= 2'h0;
            buf_ff[0] <= `SPIBM_RST_WORD;
            buf_ff[1] <= `SPIBM_RST_WORD;
        end
        else
        begin
            if (pushRx)
            begin
                // byte order on the way out
                buf_ff[wrPtr_ff] <= big_ff ? byteSwap(rxWord_ff, len_ff) : rxWord_ff;
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (popRx)
            begin
                rdPtr_ff <= ~rdPtr_ff;
            end
            count_ff <= 2'(count_ff + {1'b0, pushRx} - {1'b0, popRx});
        end
    end

endmodule

// ==== verif/spibm_assertions.sv ====
module spibm_assertions
    import spibm_pkg::*;
(
    input wire logic ref_clk, // clock
    input wire logic rst, // reset
    input wire logic enable, // enable
    input wire logic [1:0] spiMode, // mode
    input wire logic [6:0] clkDiv, // divider
    input wire logic [5:0] xferLen, // length
    input wire logic selAuto, // auto select
    input wire logic [2:0] selChoose, // auto lines
    input wire logic startReq, // start
    input wire logic startReady, // start taken
    input wire logic busy, // busy
    input wire logic doneFlag, // done
    input wire logic doneClear, // clear
    input wire logic irqEnable, // mask
    input wire logic irqOut, // irq
    input wire logic slave_select_0, // sel 0
    input wire logic slave_select_1, // sel 1
    input wire logic slave_select_2, // sel 2
    input wire logic [2:0] selOeN, // sel oe
    input wire logic serial_clock_out, // sclk
    input wire logic clkOeN, // sclk oe
    input wire logic doutOeN, // data oe
    input wire logic pullUpEn // pull-ups
);
    logic [12:0] cnt_ff;
    logic [12:0] span_ff;
    wire logic taken = startReq && startReady;
    wire logic [12:0] halfLen = (clkDiv > 7'h4f) ? 13'h0050 : 13'(clkDiv) + 13'h0001;
    wire logic [12:0] bitLen = (xferLen == 6'h00) ? 13'h0001 : (xferLen > 6'h20) ? 13'h0020 : 13'(xferLen);
    wire logic [12:0] nxt_cnt = taken ? 13'h0001 : busy ? cnt_ff + 13'h0001 : cnt_ff;
    // lead, two half periods a bit, tail and done cycle
    wire logic [12:0] nxt_span = taken ? 13'h0002 + 13'h0002 * halfLen * (bitLen + 13'h0001) : span_ff;
    always_ff @(posedge ref_clk)
    begin
        cnt_ff <= rst ? 13'h0000 : nxt_cnt;
        span_ff <= rst ? 13'h0000 : nxt_span;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence startTaken;
        startReq && startReady;
    endsequence
    sequence busyEnds;
        $fell(busy) && enable;
    endsequence
    start_busy_a: assert property (startTaken |=> busy [*2])
        else $error("busy did not follow an accepted start");
    refuse_busy_a: assert property (busy |-> !startReady)
        else $error("start offered while busy");
    done_span_a: assert property (busyEnds |-> cnt_ff == span_ff && doneFlag)
        else $error("transfer length in cycles wrong");
    idle_level_a: assert property (busyEnds |-> serial_clock_out == spiMode[1])
        else $error("serial clock not at idle level");
    auto_sel_a: assert property ($past(busy) && busy && selAuto && selChoose == 3'h1
        |-> {slave_select_2, slave_select_1, slave_select_0} == 3'b110)
        else $error("automatic select wrong during transfer");
    two_sel_a: assert property (slave_select_0 || slave_select_1 || slave_select_2)
        else $error("three selects asserted");
    reset_pins_a: assert property ($fell(rst) |-> selOeN == 3'h7 && clkOeN && doutOeN && pullUpEn
        && slave_select_0 && slave_select_1 && slave_select_2)
        else $error("pins not released by reset");
    drive_pins_a: assert property (enable && $past(enable) && !$past(rst) |-> !clkOeN && !doutOeN && !pullUpEn)
        else $error("enabled block not driving pins");
    irq_mask_a: assert property (irqOut == (doneFlag && irqEnable))
        else $error("interrupt does not follow mask");
    done_hold_a: assert property (doneFlag && !doneClear |=> doneFlag)
        else $error("done flag lost without clear");
endmodule

bind spibm_top spibm_assertions chk (.ref_clk(ref_clk), .rst(rst), .enable(enable), .spiMode(spiMode),
    .clkDiv(clkDiv), .xferLen(xferLen), .selAuto(selAuto), .selChoose(selChoose), .startReq(startReq),
    .startReady(startReady), .busy(busy), .doneFlag(doneFlag), .doneClear(doneClear), .irqEnable(irqEnable),
    .irqOut(irqOut), .slave_select_0(slave_select_0), .slave_select_1(slave_select_1),
    .slave_select_2(slave_select_2), .selOeN(selOeN), .serial_clock_out(serial_clock_out), .clkOeN(clkOeN),
    .doutOeN(doutOeN), .pullUpEn(pullUpEn));

// ==== verif/spibm_slave_model.sv ====
module spibm_slave_model (
    input wire logic sclk, // serial clock
    input wire logic mosi, // data from master
    input wire logic [2:0] selN, // selects, active low
    input wire logic [1:0] spiMode, // {polarity, phase}
    input wire logic clr, // clears capture
    output logic miso, // data to master
    output logic [31:0] wireWord, // bits seen, first on top
    output logic [5:0] wireCnt // bits seen
);
    timeunit 1ns;
    timeprecision 100ps;
    logic noise = 1'b0;
    // selected when a line is low
    wire logic picked = !(&selN);
    // an unselected line floats: show a changing level, never the last bit
    always #37 noise = ~noise;
    // answers every bit with its inverse
    assign miso = picked ? ~mosi : noise;
    always @(posedge sclk or negedge sclk or posedge clr)
    begin
        if (clr)
        begin
            wireWord <= 32'h0000_0000;
            wireCnt <= 6'h00;
        end
        else if (picked && sclk == (spiMode[1] == spiMode[0]))
        begin
            wireWord <= {wireWord[30:0], mosi};
            wireCnt <= wireCnt + 6'h01;
        end
    end
endmodule

// ==== verif/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst = 1'b1, enable = 1'b0, lsbFirst = 1'b0, bigEndian = 1'b0, sampleDelay = 1'b0;
    logic selAuto = 1'b1, startReq = 1'b0, rxReady = 1'b0, doneClear = 1'b0, irqEnable = 1'b0, wireClr = 1'b0;
    logic [1:0] spiMode = 2'h0;
    logic [6:0] clkDiv = 7'h03;
    logic [5:0] xferLen = 6'h08;
    logic [2:0] selChoose = 3'h1, selManual = 3'h0;
    logic [31:0] txData = 32'h0000_0000;
    logic startReady, busy, rxValid, doneFlag, irqOut, sel0, sel1, sel2, sclk, clkOeN, mosi, doutOeN, miso, pullUp;
    logic [2:0] selOeN;
    logic [31:0] rxData, wireWord;
    logic [5:0] wireCnt;
    logic [31:0] expQ[$], mskQ[$];
    int err_total = 0;
    int total_checks = 0;
    // half period of four cycles: a 400 ns serial clock
    always #25 ref_clk = ~ref_clk;
    spibm_top dut (.ref_clk(ref_clk), .rst(rst), .enable(enable), .spiMode(spiMode), .lsbFirst(lsbFirst),
        .bigEndian(bigEndian), .sampleDelay(sampleDelay), .clkDiv(clkDiv), .xferLen(xferLen), .selAuto(selAuto),
        .selChoose(selChoose), .selManual(selManual), .startReq(startReq), .startReady(startReady),
        .txData(txData), .busy(busy), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .doneFlag(doneFlag),
        .doneClear(doneClear), .irqEnable(irqEnable), .irqOut(irqOut), .slave_select_0(sel0),
        .slave_select_1(sel1), .slave_select_2(sel2), .selOeN(selOeN), .serial_clock_out(sclk), .clkOeN(clkOeN),
        .serial_data_out(mosi), .doutOeN(doutOeN), .serial_data_in(miso), .pullUpEn(pullUp));
    spibm_slave_model peer (.sclk(sclk), .mosi(mosi), .selN({sel2, sel1, sel0}), .spiMode(spiMode),
        .clr(wireClr), .miso(miso), .wireWord(wireWord), .wireCnt(wireCnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask
    function automatic logic [31:0] brev(input logic [31:0] w, input int nb);
        logic [31:0] r;
        r = w;
        for (int i = 0; i < nb; i++)
            r[i * 8 +: 8] = w[(nb - 1 - i) * 8 +: 8];
        return r;
    endfunction
    task automatic xfer(input logic [1:0] m, input logic lsb, big, dly, input logic [5:0] len, input logic [31:0] tx);
        logic [31:0] lm, eff, w;
        int nb, n;
        lm = 32'((64'h1 << len) - 64'h1);
        nb = (len + 7) / 8;
        eff = big ? brev(tx, nb) : tx;
        w = eff & lm;
        for (int i = 0; i < len; i++)
            if (lsb)
                w[len - 1 - i] = eff[i];
        expQ.push_back(big ? brev(~eff & lm, nb) : ~eff & lm);
        mskQ.push_back(big ? brev(lm, nb) : lm);
        @(negedge ref_clk);
        {spiMode, lsbFirst, bigEndian, sampleDelay, xferLen, txData} = {m, lsb, big, dly, len, tx};
        doneClear = 1;
        @(negedge ref_clk);
        doneClear = 0;
        chk_bit("done cleared", 1'b0, doneFlag);
        startReq = 1;
        @(negedge ref_clk);
        wireClr = 1;
        chk_bit("busy", 1'b1, busy);
        // the request still stands while busy and must be ignored
        @(negedge ref_clk);
        wireClr = 0;
        startReq = 0;
        n = 0;
        while ((busy !== 1'b0 || doneFlag !== 1'b1) && n < 3000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 3000)
        begin
            err_total++;
            $display("FAIL completion expected done seen busy");
            complete_run();
        end
        chk_word("wire bits", w, wireWord);
        chk_word("bit count", {26'h0, len}, {26'h0, wireCnt});
        chk_bit("irq", irqEnable, irqOut);
        repeat (2) @(negedge ref_clk);
        if (selAuto)
            chk_word("auto selects", 32'h7, {29'h0, sel2, sel1, sel0});
    endtask
    task automatic pop(input int k);
        for (int j = 0; j < k; j++)
        begin
            @(negedge ref_clk);
            rxReady = 1;
            chk_bit("rx valid", 1'b1, rxValid);
            chk_word("rx data", expQ[0] & mskQ[0], rxData & mskQ[0]);
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
        @(negedge ref_clk);
        rxReady = 0;
        chk_bit("rx empty", 1'b0, rxValid);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [5:0] len;
        void'($urandom(58));
        repeat (12) @(negedge ref_clk);
        chk_word("reset pins", 32'h3f, {26'h0, selOeN, clkOeN, doutOeN, pullUp});
        rst = 0;
        enable = 1;
        repeat (2) @(negedge ref_clk);
        chk_word("pins driven", 32'h0, {26'h0, selOeN, clkOeN, doutOeN, pullUp});
        for (int i = 0; i < 16; i++)
        begin
            len = (i % 4 == 0) ? 6'h01 : (i % 4 == 1) ? 6'h20 : 6'($urandom_range(31, 2));
            irqEnable = i[0];
            selChoose = i[1] ? 3'h3 : 3'h1;
            xfer(2'(i), i[2], i[3], 1'($urandom_range(1, 0)), len, $urandom);
            pop(1);
        end
        // buffer holds two words, then refuses the next start
        xfer(2'h0, 1'b0, 1'b0, 1'b0, 6'h10, $urandom);
        xfer(2'h3, 1'b1, 1'b0, 1'b0, 6'h07, $urandom);
        chk_bit("start ready full", 1'b0, startReady);
        // a start offered while the buffer is full must be ignored
        startReq = 1;
        @(negedge ref_clk);
        startReq = 0;
        chk_bit("start refused", 1'b0, busy);
        pop(2);
        selAuto = 0;
        selManual = 3'h3;
        xfer(2'h3, 1'b0, 1'b1, 1'b0, 6'h18, $urandom);
        chk_word("held selects", 32'h4, {29'h0, sel2, sel1, sel0});
        xfer(2'h3, 1'b1, 1'b1, 1'b1, 6'h1f, $urandom);
        pop(2);
        selManual = 3'h7;
        repeat (2) @(negedge ref_clk);
        chk_word("three requested", 32'h4, {29'h0, sel2, sel1, sel0});
        selManual = 3'h0;
        repeat (2) @(negedge ref_clk);
        chk_word("released selects", 32'h7, {29'h0, sel2, sel1, sel0});
        enable = 0;
        repeat (2) @(negedge ref_clk);
        chk_word("pins released", 32'h3f, {26'h0, selOeN, clkOeN, doutOeN, pullUp});
        complete_run();
    end
endmodule
